// ### core/usam_core.sv
`timescale 1ns/1ps
// Functional notes
// [RL1] Mode 0: eight bits, LSB first, clock out.
// [RL2] Fixed Mode 0 rate: /4,/2 fast, /6,/3.
// [RL3] Timer 1 Mode 0 rate: overflow /4 or /2.
// [RL4] Baud generator Mode 0 rate: overflow /2 or /1.
// [RL5] Mode 0 write loads marker, starts within slot.
// [RL6] Mode 0 send drives data and clock, ends.
// [RL7] Mode 0 receive starts on enable, preloads 11111110.
// [RL8] Mode 0 receive final shift loads buffer, flags.
// [RL9] Mode 0 clock idle level follows filter bit.
// [RL10] Mode 0 data edges follow double rate select.
// [RL11] Software holds filter bit and latch during bytes.
// [RL12] Mode 1 frame: start, eight bits, stop.
// [RL13] Mode 1 rates from timer 1 or 2.
// [RL14] Mode 1 send starts after next rollover.
// [RL15] Start bit, then data, then first shift.
// [RL16] Mode 1 send ends at tenth rollover.
// [RL17] Receiver oversamples 16x, edge resets counter.
// [RL18] Majority vote of samples 7, 8, 9.
// [RL19] Non-zero start bit restarts edge search.
// [RL20] Final shift accepts frame only if allowed.
// [RL21] Accepted frame fills buffer, ninth bit, flag.
// [RL22] Done flags cleared only by software.
module usam_core (
  input  wire logic               ref_clk_i,
  input  wire logic               arst_n_i,
  input  wire usam_pkg::usam_cfg_s cfg_i,
  input  wire usam_pkg::usam_rate_s rate_i,
  input  wire logic               serial_data_buffer_wr_i,
  input  wire logic [7:0]         serial_data_buffer_wdata_i,
  input  wire logic               tx_done_clr_i,
  input  wire logic               rx_done_clr_i,
  input  wire logic               rxd_i,
  output logic                    rxd_o,
  output logic                    rxd_oe_o,
  output logic                    txd_o,
  output logic [7:0]              serial_data_buffer_o,
  output logic                    rx_ninth_bit_o,
  output logic                    tx_done_flag_o,
  output logic                    rx_done_flag_o,
  output logic                    send_phase_o,
  output logic                    receive_phase_o
);

  usam_pkg::usam_state_s st_reg;
  usam_pkg::usam_state_s st_next;

  // Bit reversal: both receivers shift in at the right, so the first bit lands leftmost.
  function automatic logic [7:0] usam_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  // Mode 0 slot timing signals.
  logic                       m0_tick;
  logic [usam_pkg::DIV_W-1:0] m0_div;
  logic [usam_pkg::DIV_W-1:0] m0_half;
  logic                       slot_end;
  logic                       slot_mid;
  logic                       in_h1;
  logic                       non_idle;
  logic                       m0_sample;
  logic                       m0_active;
  // Mode 1 rate signals.
  logic                       tx_tick;
  logic                       rx_tick;
  logic                       tx_roll;
  logic                       vote;
  logic                       rx_in_bit;

  // Mode 0 divisor and source selection.
  always_comb begin
    if (cfg_i.mode0_rate_source) begin
      m0_tick = rate_i.baud_gen_ovf; // [RL4]
      m0_div  = cfg_i.double_rate_select ? usam_pkg::DIV_BRG_DOUBLE : usam_pkg::DIV_BRG_SLOW;
    end else if (cfg_i.tx_ninth_bit) begin
      m0_tick = rate_i.timer1_ovf; // [RL3]
      m0_div  = cfg_i.double_rate_select ? usam_pkg::DIV_T1_DOUBLE : usam_pkg::DIV_T1_SLOW;
    end else if (cfg_i.fast_mode) begin
      m0_tick = 1'b1; // [RL2]
      m0_div  = cfg_i.double_rate_select ? usam_pkg::DIV_FAST_DOUBLE : usam_pkg::DIV_FAST_SLOW;
    end else begin
      m0_tick = 1'b1; // [RL2]
      m0_div  = cfg_i.double_rate_select ? usam_pkg::DIV_COMP_DOUBLE : usam_pkg::DIV_COMP_SLOW;
    end
  end

  // A slot has two halves; the clock leaves idle in one of them.
  // With a divisor of one there is no mid point, so the clock holds one level all transfer: idle when it idles high, non-idle when it idles low.
  assign m0_half   = m0_div >> 1;
  assign slot_end  = m0_tick && (st_reg.div_cnt == m0_div - 3'h1);
  assign slot_mid  = (m0_half == 3'h0) ? slot_end : (m0_tick && (st_reg.div_cnt == m0_half - 3'h1));
  assign in_h1     = (st_reg.div_cnt >= m0_half);
  // Idle high with double rate puts the low half first, so data changes one cycle before the fall.
  assign non_idle  = (!cfg_i.clock_idle_or_addr_filter && cfg_i.double_rate_select) ? !in_h1 : in_h1; // [RL10]
  assign m0_sample = cfg_i.double_rate_select ? slot_mid : slot_end; // [RL10]
  assign m0_active = (st_reg.tx_st == usam_pkg::USAM_TX_DATA) || (st_reg.rx_st == usam_pkg::USAM_RX_BITS);

  // Mode 1 oversampling ticks, one timer per direction.
  assign tx_tick   = cfg_i.tx_timer2_sel ? rate_i.timer2_ovf : rate_i.timer1_ovf; // [RL13]
  assign rx_tick   = cfg_i.rx_timer2_sel ? rate_i.timer2_ovf : rate_i.timer1_ovf; // [RL13]
  assign tx_roll   = tx_tick && (st_reg.tx_c16 == usam_pkg::C16_LAST);
  assign vote      = (st_reg.samples[0] & st_reg.samples[1]) | (st_reg.samples[0] & st_reg.samples[2])
                   | (st_reg.samples[1] & st_reg.samples[2]); // [RL18]
  assign rx_in_bit = cfg_i.double_rate_select ? st_reg.m0_bit : st_reg.filt;

  // Next-state logic for the whole port.
  always_comb begin
    st_next = st_reg;

    // Pin synchroniser; a change counts once stages two and three agree.
    st_next.sync = {st_reg.sync[1:0], rxd_i};
    if (st_reg.sync[1] == st_reg.sync[2]) begin
      st_next.filt = st_reg.sync[2];
    end

    // Done flags: software clears, a same-cycle set below wins.
    if (tx_done_clr_i) begin
      st_next.ti = 1'b0; // [RL22]
    end
    if (rx_done_clr_i) begin
      st_next.ri = 1'b0; // [RL22]
    end

    if (!cfg_i.mode1) begin
      // Free-running slot counter; a request waits at most one slot for alignment.
      if (m0_tick) begin
        st_next.div_cnt = slot_end ? '0 : st_reg.div_cnt + 3'h1;
      end
      if (m0_sample) begin
        st_next.m0_bit = st_reg.filt;
      end

      // Mode 0 transmit.
      case (st_reg.tx_st)
        usam_pkg::USAM_TX_WAIT: begin
          if (slot_end) begin
            st_next.tx_st = usam_pkg::USAM_TX_DATA; // [RL5]
          end
        end
        usam_pkg::USAM_TX_DATA: begin
          if (slot_end) begin
            st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]}; // [RL6]
            if (st_reg.tx_shift[8:1] == usam_pkg::TX_END_PAT) begin
              st_next.tx_st = usam_pkg::USAM_TX_IDLE; // [RL6]
              st_next.ti    = 1'b1; // [RL6]
            end
          end
        end
        default: begin
          st_next.tx_st = usam_pkg::USAM_TX_IDLE;
        end
      endcase

      // Mode 0 receive, started only while the line is not sending.
      case (st_reg.rx_st)
        usam_pkg::USAM_RX_IDLE: begin
          if (cfg_i.rx_enable_bit && !st_reg.ri && (st_reg.tx_st == usam_pkg::USAM_TX_IDLE) && !serial_data_buffer_wr_i) begin
            st_next.rx_st = usam_pkg::USAM_RX_ARM; // [RL7]
          end
        end
        usam_pkg::USAM_RX_ARM: begin
          st_next.rx_shift = usam_pkg::RX0_PRELOAD; // [RL7]
          if (slot_end) begin
            st_next.rx_st = usam_pkg::USAM_RX_BITS; // [RL7]
          end
        end
        usam_pkg::USAM_RX_BITS: begin
          if (slot_end) begin
            st_next.rx_shift = {1'b0, st_reg.rx_shift[6:0], rx_in_bit}; // [RL8]
            if (!st_reg.rx_shift[7]) begin
              st_next.serial_data_buffer  = usam_rev8({st_reg.rx_shift[6:0], rx_in_bit}); // [RL1] [RL8]
              st_next.ri    = 1'b1; // [RL8]
              st_next.rx_st = usam_pkg::USAM_RX_IDLE; // [RL8]
            end
          end
        end
        default: begin
          st_next.rx_st = usam_pkg::USAM_RX_IDLE;
        end
      endcase
    end else begin
      // Mode 1 transmit, timed by its own divide-by-16 counter.
      if (tx_tick) begin
        st_next.tx_c16 = st_reg.tx_c16 + 4'h1;
      end
      case (st_reg.tx_st)
        usam_pkg::USAM_TX_WAIT: begin
          if (tx_roll) begin
            st_next.tx_st = usam_pkg::USAM_TX_START; // [RL14] [RL15]
          end
        end
        usam_pkg::USAM_TX_START: begin
          if (tx_roll) begin
            st_next.tx_st = usam_pkg::USAM_TX_DATA; // [RL15]
          end
        end
        usam_pkg::USAM_TX_DATA: begin
          if (tx_roll) begin
            st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]}; // [RL15]
            if (st_reg.tx_shift[8:1] == usam_pkg::TX_END_PAT) begin
              st_next.tx_st = usam_pkg::USAM_TX_IDLE; // [RL16]
              st_next.ti    = 1'b1; // [RL16]
            end
          end
        end
        default: begin
          st_next.tx_st = usam_pkg::USAM_TX_IDLE;
        end
      endcase

      // Mode 1 receive: edge hunt, majority vote and frame assembly.
      if (rx_tick) begin
        st_next.prev_rx = st_reg.filt;
      end
      case (st_reg.rx_st)
        usam_pkg::USAM_RX_BITS: begin
          if (rx_tick) begin
            st_next.rx_c16 = st_reg.rx_c16 + 4'h1; // [RL17]
            if (st_reg.rx_c16 == usam_pkg::C16_SMP_A) begin
              st_next.samples[0] = st_reg.filt; // [RL18]
            end
            if (st_reg.rx_c16 == usam_pkg::C16_SMP_B) begin
              st_next.samples[1] = st_reg.filt; // [RL18]
            end
            if (st_reg.rx_c16 == usam_pkg::C16_SMP_C) begin
              st_next.samples[2] = st_reg.filt; // [RL18]
            end
            if (st_reg.rx_c16 == usam_pkg::C16_LAST) begin
              st_next.rx_first = 1'b0;
              st_next.rx_shift = {st_reg.rx_shift[7:0], vote};
              if (st_reg.rx_first && vote) begin
                st_next.rx_st = usam_pkg::USAM_RX_IDLE; // [RL19]
              end else if (!st_reg.rx_first && !st_reg.rx_shift[8]) begin
                st_next.rx_st = usam_pkg::USAM_RX_IDLE; // [RL21]
                if (!st_reg.ri && (!cfg_i.clock_idle_or_addr_filter || vote)) begin // [RL20]
                  st_next.serial_data_buffer = usam_rev8(st_reg.rx_shift[7:0]); // [RL12] [RL21]
                  st_next.rb8  = vote; // [RL12] [RL21]
                  st_next.ri   = 1'b1; // [RL21]
                end
              end
            end
          end
        end
        default: begin
          st_next.rx_st = usam_pkg::USAM_RX_IDLE;
          if (rx_tick && st_reg.prev_rx && !st_reg.filt) begin
            st_next.rx_c16   = '0; // [RL17]
            st_next.rx_shift = usam_pkg::RX1_PRELOAD; // [RL17]
            st_next.rx_first = 1'b1;
            st_next.rx_st    = usam_pkg::USAM_RX_BITS;
          end
        end
      endcase
    end

    // A buffer write always restarts the transmitter with the marker loaded.
    if (serial_data_buffer_wr_i) begin
      st_next.tx_shift = {1'b1, serial_data_buffer_wdata_i}; // [RL5] [RL14]
      st_next.tx_st    = usam_pkg::USAM_TX_WAIT; // [RL5] [RL14]
    end

    // Pin drive, registered; the Mode 0 clock from the current state, the rest from the state being entered.
    if (!cfg_i.mode1) begin
      if (m0_active) begin
        st_next.txd = non_idle ? cfg_i.clock_idle_or_addr_filter : !cfg_i.clock_idle_or_addr_filter; // [RL6]
      end else begin
        st_next.txd = !cfg_i.clock_idle_or_addr_filter; // [RL9]
      end
      // The port latch can hold the data line low, which software uses for line edges.
      st_next.rxd_oe  = (st_next.tx_st == usam_pkg::USAM_TX_DATA) || !cfg_i.port3_bit0_latch;
      st_next.rxd_out = (st_next.tx_st == usam_pkg::USAM_TX_DATA) ? (st_next.tx_shift[0] & cfg_i.port3_bit0_latch)
                                                                : 1'b0; // [RL1] [RL6] [RL11]
    end else begin
      st_next.rxd_oe  = 1'b0;
      st_next.rxd_out = 1'b0;
      case (st_next.tx_st)
        usam_pkg::USAM_TX_START: st_next.txd = 1'b0; // [RL12] [RL15]
        usam_pkg::USAM_TX_DATA:  st_next.txd = st_next.tx_shift[0]; // [RL15]
        default:                 st_next.txd = 1'b1; // [RL12]
      endcase
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg          <= '0;
      st_reg.sync     <= usam_pkg::SYNC_RST;
      st_reg.filt     <= 1'b1;
      st_reg.prev_rx  <= 1'b1;
      st_reg.tx_st    <= usam_pkg::USAM_TX_IDLE;
      st_reg.rx_st    <= usam_pkg::USAM_RX_IDLE;
      st_reg.serial_data_buffer     <= usam_pkg::SERIAL_DATA_BUFFER_RST;
      st_reg.txd      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register.
  assign rxd_o                = st_reg.rxd_out;
  assign rxd_oe_o             = st_reg.rxd_oe;
  assign txd_o                = st_reg.txd;
  assign serial_data_buffer_o = st_reg.serial_data_buffer;
  assign rx_ninth_bit_o       = st_reg.rb8;
  assign tx_done_flag_o       = st_reg.ti;
  assign rx_done_flag_o       = st_reg.ri;
  assign send_phase_o         = (st_reg.tx_st == usam_pkg::USAM_TX_DATA) || (st_reg.tx_st == usam_pkg::USAM_TX_START);
  assign receive_phase_o      = (st_reg.rx_st == usam_pkg::USAM_RX_BITS);

endmodule

// ### pkg/usam_pkg.sv
package usam_pkg;

  // Counter widths shared by the core.
  localparam int unsigned DIV_W = 3;
  localparam int unsigned C16_W = 4;

  // Mode 0 slot divisors in ticks of the selected source.
  localparam logic [DIV_W-1:0] DIV_FAST_SLOW   = 3'h4;
  localparam logic [DIV_W-1:0] DIV_FAST_DOUBLE = 3'h2;
  localparam logic [DIV_W-1:0] DIV_COMP_SLOW   = 3'h6;
  localparam logic [DIV_W-1:0] DIV_COMP_DOUBLE = 3'h3;
  localparam logic [DIV_W-1:0] DIV_T1_SLOW     = 3'h4;
  localparam logic [DIV_W-1:0] DIV_T1_DOUBLE   = 3'h2;
  localparam logic [DIV_W-1:0] DIV_BRG_SLOW    = 3'h2;
  localparam logic [DIV_W-1:0] DIV_BRG_DOUBLE  = 3'h1;

  // Divide-by-16 counter: last state and the three majority sample states.
  localparam logic [C16_W-1:0] C16_LAST  = 4'hf;
  localparam logic [C16_W-1:0] C16_SMP_A = 4'h6;
  localparam logic [C16_W-1:0] C16_SMP_B = 4'h7;
  localparam logic [C16_W-1:0] C16_SMP_C = 4'h8;

  // Shift register preloads and the transmit end pattern.
  localparam logic [8:0] RX0_PRELOAD = 9'h0fe;
  localparam logic [8:0] RX1_PRELOAD = 9'h1ff;
  localparam logic [7:0] TX_END_PAT  = 8'h01;

  // Reset values.
  localparam logic [7:0] SERIAL_DATA_BUFFER_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;

  // Transmit sequencer, Gray coded along idle-wait-start-data.
  typedef enum logic [1:0] {
    USAM_TX_IDLE  = 2'b00,
    USAM_TX_WAIT  = 2'b01,
    USAM_TX_START = 2'b11,
    USAM_TX_DATA  = 2'b10
  } usam_tx_e;

  // Receive sequencer, Gray coded along idle-arm-bits.
  typedef enum logic [1:0] {
    USAM_RX_IDLE = 2'b00,
    USAM_RX_ARM  = 2'b01,
    USAM_RX_BITS = 2'b11
  } usam_rx_e;

  // Static configuration bits from software.
  typedef struct packed {
    logic mode1;
    logic fast_mode;
    logic double_rate_select;
    logic mode0_rate_source;
    logic tx_ninth_bit;
    logic clock_idle_or_addr_filter;
    logic rx_enable_bit;
    logic port3_bit0_latch;
    logic tx_timer2_sel;
    logic rx_timer2_sel;
  } usam_cfg_s;

  // Rate source pulses, one system clock wide each.
  typedef struct packed {
    logic timer1_ovf;
    logic timer2_ovf;
    logic baud_gen_ovf;
  } usam_rate_s;

  // Whole state of the core.
  typedef struct packed {
    logic [2:0]       sync;
    logic             filt;
    logic             prev_rx;
    logic [DIV_W-1:0] div_cnt;
    logic [C16_W-1:0] tx_c16;
    logic [C16_W-1:0] rx_c16;
    usam_tx_e         tx_st;
    usam_rx_e         rx_st;
    logic [8:0]       tx_shift;
    logic [8:0]       rx_shift;
    logic             rx_first;
    logic [2:0]       samples;
    logic             m0_bit;
    logic [7:0]       serial_data_buffer;
    logic             rb8;
    logic             ti;
    logic             ri;
    logic             txd;
    logic             rxd_out;
    logic             rxd_oe;
  } usam_state_s;

endpackage

// ### tb/usam_chk.sv
`timescale 1ns/1ps
// Watches the serial core from its ports and flags broken done-flag, idle-level, start-bit, data-drive and buffer-hold relations.
module usam_chk (
  input wire logic                ref_clk_i,
  input wire logic                arst_n_i,
  input wire usam_pkg::usam_cfg_s cfg_i,
  input wire logic                serial_data_buffer_wr_i,
  input wire logic                tx_done_clr_i,
  input wire logic                rx_done_clr_i,
  input wire logic                txd_o,
  input wire logic                rxd_oe_o,
  input wire logic [7:0]          serial_data_buffer_o,
  input wire logic                rx_ninth_bit_o,
  input wire logic                tx_done_flag_o,
  input wire logic                rx_done_flag_o,
  input wire logic                send_phase_o,
  input wire logic                receive_phase_o
);
  logic [1:0] age_reg;
  logic       settled;

  // Idle checks wait out the first edges after reset, where outputs still hold reset values.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  assign settled = (age_reg == 2'h3);

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_ti_sticky: assert property (tx_done_flag_o && !tx_done_clr_i |=> tx_done_flag_o)
    else $error("tx done flag dropped without a clear");
  chk_ri_sticky: assert property (rx_done_flag_o && !rx_done_clr_i |=> rx_done_flag_o)
    else $error("rx done flag dropped without a clear");
  chk_m0_idle_clk: assert property (settled && !cfg_i.mode1 && $stable(cfg_i) && !send_phase_o
    && !receive_phase_o && !$past(send_phase_o) && !$past(receive_phase_o)
    |-> txd_o == !cfg_i.clock_idle_or_addr_filter) else $error("shift clock not at idle level");
  chk_m1_line_idle: assert property (settled && cfg_i.mode1 && $past(cfg_i.mode1)
    && !send_phase_o && !$past(send_phase_o) |-> txd_o) else $error("tx line not high outside frame");
  chk_m1_start_bit: assert property (cfg_i.mode1 && $rose(send_phase_o) |-> !txd_o [*8])
    else $error("start bit missing or short");
  chk_m0_data_drive: assert property (!cfg_i.mode1 && send_phase_o && $past(send_phase_o)
    && cfg_i.port3_bit0_latch |-> rxd_oe_o) else $error("data pin not driven while sending");
  chk_send_end_flag: assert property ($fell(send_phase_o) && !$past(serial_data_buffer_wr_i) |-> ##[0:1] tx_done_flag_o)
    else $error("send ended without tx done");
  chk_ti_cause: assert property ($rose(tx_done_flag_o) |-> $past(send_phase_o) || $past(send_phase_o, 2))
    else $error("tx done set with no send");
  chk_ri_phase_end: assert property ($rose(rx_done_flag_o) |-> !receive_phase_o)
    else $error("rx done set while still receiving");
  chk_ri_blocks_load: assert property ($past(rx_done_flag_o) && !$past(rx_done_clr_i) && !$past(serial_data_buffer_wr_i)
    |-> $stable(serial_data_buffer_o) && $stable(rx_ninth_bit_o)) else $error("frame loaded over pending one");

  cover property (cfg_i.mode1 && $rose(tx_done_flag_o));
  cover property (cfg_i.mode1 && $rose(rx_done_flag_o));
  cover property (!cfg_i.mode1 && $rose(tx_done_flag_o));
  cover property (!cfg_i.mode1 && $rose(rx_done_flag_o));
endmodule

// ### tb/usam_peer.sv
`timescale 1ns/1ps
// Remote asynchronous sender; its line idles high as a pulled-up line does.
module usam_peer (
  input  wire logic ref_clk_i,
  output logic      line_o
);
  initial line_o = 1'b1;

  // Waits n edges, then moves off the edge so changes never race the sampling clock.
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // One frame of bt clocks a bit; glitch sends only a short start, spike flips one sample slot.
  task automatic send(input logic [7:0] d, input logic stop, input logic glitch, input logic spike, input int bt);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    if (glitch) begin
      line_o = 1'b0;
      wt(8);
      line_o = 1'b1;
      wt(10 * bt);
    end else begin
      for (int b = 0; b < 10; b++) begin
        line_o = f[b];
        wt(15);
        if (spike) line_o = ~f[b];
        wt(2);
        line_o = f[b];
        wt(bt - 17);
      end
    end
    line_o = 1'b1;
    wt(bt);
  endtask
endmodule

// ### tb/uart_shift_and_async_modes_tb.sv
`timescale 1ns/1ps
module uart_shift_and_async_modes_tb;
  localparam logic [3:0] M0_SEL [7] = '{4'h8, 4'hc, 4'h0, 4'h4, 4'h1, 4'hd, 4'h2};
  localparam int         M0_PER [7] = '{4, 2, 6, 3, 8, 4, 4};
  localparam logic [5:0] RX_CASE [6] = '{6'h22, 6'h21, 6'h10, 6'h03, 6'h28, 6'h27};

  logic                 ref_clk = 1'b0;
  logic                 arst_n;
  usam_pkg::usam_cfg_s  cfg;
  usam_pkg::usam_rate_s rate = '0;
  logic [2:0]           rcnt = 3'h0;
  logic                 serial_data_buffer_wr, tx_clr, rx_clr, rxd_o, rxd_oe, txd_o, rb8, ti, ri, sp, rp, peer_line, rxd_pin;
  logic [7:0]           serial_data_buffer_wdata, serial_data_buffer, d, eb;
  logic [9:0]           fr;
  logic                 er, eri, pt;
  int                   miscompares, num_checks, n, per, last, k;

  always #10 ref_clk = ~ref_clk;

  // Overflow pulses: timer 1 and the baud generator every 2 clocks, timer 2 every 3.
  always @(posedge ref_clk) begin
    rcnt <= (rcnt == 3'h5) ? 3'h0 : rcnt + 3'h1;
    rate.timer1_ovf <= !rcnt[0];
    rate.baud_gen_ovf <= rcnt[0];
    rate.timer2_ovf <= (rcnt == 3'h0) || (rcnt == 3'h3);
  end

  // The data pin carries the core's drive while enabled, the peer's line otherwise.
  assign rxd_pin = rxd_oe ? rxd_o : peer_line;

  usam_core dut (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .cfg_i(cfg), .rate_i(rate), .serial_data_buffer_wr_i(serial_data_buffer_wr),
    .serial_data_buffer_wdata_i(serial_data_buffer_wdata), .tx_done_clr_i(tx_clr), .rx_done_clr_i(rx_clr), .rxd_i(rxd_pin), .rxd_o(rxd_o),
    .rxd_oe_o(rxd_oe), .txd_o(txd_o), .serial_data_buffer_o(serial_data_buffer), .rx_ninth_bit_o(rb8),
    .tx_done_flag_o(ti), .rx_done_flag_o(ri), .send_phase_o(sp), .receive_phase_o(rp));
  usam_peer peer (.ref_clk_i(ref_clk), .line_o(peer_line));

  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wr_byte(input logic [7:0] v);
    serial_data_buffer_wdata = v;
    serial_data_buffer_wr = 1'b1;
    step;
    serial_data_buffer_wr = 1'b0;
  endtask

  task automatic clr_ti;
    tx_clr = 1'b1;
    step;
    tx_clr = 1'b0;
  endtask

  task automatic clr_ri;
    rx_clr = 1'b1;
    step;
    rx_clr = 1'b0;
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmp_val(input string nm, input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // A hang in any wait loop is cut short well after the longest expected run.
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    finish_test;
  end

  initial begin
    void'($urandom(32'h4759269d));
    arst_n = 1'b0;
    cfg = '0;
    cfg.fast_mode = 1'b1;
    cfg.port3_bit0_latch = 1'b1;
    serial_data_buffer_wr = 1'b0;
    serial_data_buffer_wdata = 8'h00;
    tx_clr = 1'b0;
    rx_clr = 1'b0;
    eb = 8'h00;
    er = 1'b0;
    eri = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    step;
    step;
    // Idle level of the shift clock for both settings of the filter bit.
    for (int i = 0; i < 2; i++) begin
      cfg.clock_idle_or_addr_filter = ~i[0];
      repeat (3) step;
      cmp_bit("m0 idle clock", i[0], txd_o);
    end
    // Every Mode 0 rate source; data is taken when the clock leaves its high idle level.
    for (int i = 0; i < 7; i++) begin
      {cfg.fast_mode, cfg.double_rate_select, cfg.mode0_rate_source, cfg.tx_ninth_bit} = M0_SEL[i];
      repeat (4) step;
      d = 8'($urandom);
      wr_byte(d);
      n = 0;
      last = 0;
      pt = 1'b1;
      fr = '0;
      for (k = 0; k < 300 && ti !== 1'b1; k++) begin
        if (pt && !txd_o && n < 8) begin
          fr[n] = rxd_o;
          per = k - last;
          last = k;
          n++;
        end
        pt = txd_o;
        step;
      end
      cmp_val("m0 byte", {2'h0, d}, fr);
      cmp_val("m0 period", 10'(M0_PER[i]), 10'(per));
      cmp_bit("m0 done", 1'b1, ti);
      clr_ti;
      cmp_bit("m0 done clear", 1'b0, ti);
    end
    // Mode 0 receive from an undriven, pulled-up data pin: eight ones, then the done flag.
    cfg.rx_enable_bit = 1'b1;
    repeat (80) step;
    cmp_bit("m0 rx drive off", 1'b0, rxd_oe);
    cmp_val("m0 rx buffer", 10'h0ff, {2'h0, serial_data_buffer});
    cmp_bit("m0 rx done", 1'b1, ri);
    // Disable first so the cleared flag does not start another receive.
    cfg.rx_enable_bit = 1'b0;
    step;
    clr_ri;
    cmp_bit("m0 rx done clear", 1'b0, ri);
    // Mode 1 send on timer 2 ticks: a bit lasts 48 clocks, sampled mid-bit.
    cfg.mode1 = 1'b1;
    cfg.tx_timer2_sel = 1'b1;
    cfg.rx_enable_bit = 1'b1;
    repeat (4) step;
    d = 8'($urandom);
    wr_byte(d);
    for (k = 0; k < 70 && txd_o !== 1'b0; k++) step;
    cmp_bit("m1 start wait", 1'b1, k < 70);
    repeat (24) step;
    for (int b = 0; b < 10; b++) begin
      fr[b] = txd_o;
      if (b == 8) cmp_bit("m1 early done", 1'b0, ti);
      if (b < 9) repeat (48) step;
    end
    cmp_val("m1 frame", {1'b1, d, 1'b0}, fr);
    cmp_bit("m1 done", 1'b1, ti);
    // Receive cases: accept, pending flag, filtered stop, zero stop, false start, noisy bits.
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      cfg.clock_idle_or_addr_filter = RX_CASE[i][4];
      peer.send(d, RX_CASE[i][5], RX_CASE[i][3], RX_CASE[i][2], 32);
      repeat (40) step;
      if (RX_CASE[i][1]) begin
        eb = d;
        er = RX_CASE[i][5];
        eri = 1'b1;
      end
      cmp_val("rx buffer", {2'h0, eb}, {2'h0, serial_data_buffer});
      cmp_bit("rx ninth", er, rb8);
      cmp_bit("rx done", eri, ri);
      if (RX_CASE[i][0]) begin
        clr_ri;
        eri = 1'b0;
      end
    end
    finish_test;
  end
endmodule

bind usam_core usam_chk chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cfg_i(cfg_i), .serial_data_buffer_wr_i(serial_data_buffer_wr_i),
  .tx_done_clr_i(tx_done_clr_i), .rx_done_clr_i(rx_done_clr_i), .txd_o(txd_o), .rxd_oe_o(rxd_oe_o),
  .serial_data_buffer_o(serial_data_buffer_o), .rx_ninth_bit_o(rx_ninth_bit_o), .tx_done_flag_o(tx_done_flag_o),
  .rx_done_flag_o(rx_done_flag_o), .send_phase_o(send_phase_o), .receive_phase_o(receive_phase_o));
